// ---- ocs_map.vh ----
// Constants for the offset calibration sequencer
`ifndef OCS_MAP_VH
`define OCS_MAP_VH
`define OCS_CLK_MHZ 100
`define OCS_PON_MS 200
`define OCS_PON_CYC (`OCS_PON_MS * 1000 * `OCS_CLK_MHZ)
`define OCS_CON_MS 3
`define OCS_CON_CYC (`OCS_CON_MS * 1000 * `OCS_CLK_MHZ)
`define OCS_CORR_CYC 32
// Settling takes what the correction steps leave of the pin turn-on time
`define OCS_SETTLE_CYC (`OCS_CON_CYC - `OCS_CORR_CYC)
`define OCS_CNT_W 25
`define OCS_CAL_W 8
// Correction code: mid-scale start, saturating end points, unit step
`define OCS_CODE_RST 8'h80
`define OCS_CODE_MIN 8'h00
`define OCS_CODE_MAX 8'hff
`define OCS_CODE_STEP 8'h01
`endif

// ---- ocs_offset_core.v ----
// Offset correction step: settle, then walk the correction code, then store it
`timescale 1ns/10ps
`include "ocs_map.vh"
module ocs_offset_core #(
	parameter SETTLE_CYC = `OCS_SETTLE_CYC
) (
	input wire sys_clk_in, // System clock
	input wire rst_b_in, // Synchronous reset, active low
	input wire start_in, // One-cycle start pulse
	input wire comp_in, // Offset comparator: 1 means offset positive
	output reg busy_out, // Correction in progress
	output reg done_out, // One-cycle done pulse
	output reg store_out, // One-cycle store strobe for the memory
	output reg [`OCS_CAL_W-1:0] code_out // Correction code
);
	reg [`OCS_CNT_W-1:0] cnt_reg;
	reg settle_reg;

	always @(posedge sys_clk_in) begin
		done_out <= 1'b0;
		store_out <= 1'b0;
		if (!rst_b_in) begin
			busy_out <= 1'b0;
			settle_reg <= 1'b0;
			cnt_reg <= {`OCS_CNT_W{1'b0}};
			code_out <= `OCS_CODE_RST;
		end else if (start_in) begin
			busy_out <= 1'b1;
			settle_reg <= 1'b1;
			cnt_reg <= {`OCS_CNT_W{1'b0}};
		end else if (busy_out) begin
			cnt_reg <= cnt_reg + 1'b1;
			if (settle_reg) begin
				// Bias point must settle before any correction step
				if (cnt_reg == SETTLE_CYC - 1) begin
					settle_reg <= 1'b0;
					cnt_reg <= {`OCS_CNT_W{1'b0}};
				end
			end else begin
				if (comp_in && code_out != `OCS_CODE_MIN)
					code_out <= code_out - `OCS_CODE_STEP;
				else if (!comp_in && code_out != `OCS_CODE_MAX)
					code_out <= code_out + `OCS_CODE_STEP;
				if (cnt_reg == `OCS_CORR_CYC - 1) begin
					busy_out <= 1'b0;
					done_out <= 1'b1;
					store_out <= 1'b1;
				end
			end
		end
	end
endmodule // ocs_offset_core

// ---- ocs_seq.v ----
// Top of the offset calibration sequencer
// Contract
// - Outside calibration, while the calibrate input is high the part stays in low power with its output high impedance.
// - A falling calibrate input starts an offset calibration sequence.
// - When calibration completes the output goes low impedance and normal operation resumes.
// - Every calibration first waits a settling delay, then performs the offset correction.
// - The supply monitor reset triggers a calibration at power-up and after a low supply.
// - A low supply forces the low-power state.
// - On supply recovery a delay counter runs, then calibration starts, about 200 ms in total.
// - A parity error in calibration memory acts as a supply-monitor reset event.
// - A pin-started calibration returns to normal operation in about 3 ms.
// - During calibration the output is high impedance and inputs go to the internal buffer network.
// - The resulting constants are stored in memory at the end of correction.
// - The calibrate input defaults low, so an open input gives normal operation.
// - The common-mode divider is connected to the supplies only while calibrating.
`timescale 1ns/10ps
`include "ocs_map.vh"
module ocs_seq #(
	parameter PON_CYC = `OCS_PON_CYC,
	parameter CON_CYC = `OCS_CON_CYC,
	parameter SETTLE_CYC = `OCS_SETTLE_CYC
) (
	input wire sys_clk_in, // System clock, 100 MHz
	input wire rst_b_in, // Synchronous reset, active low
	input wire cal_chip_select_first_in, // Calibrate/chip select, high = low power
	input wire supply_low_in, // Supply monitor: supply too low
	input wire parity_err_in, // Calibration memory parity error
	input wire comp_in, // Offset comparator during correction
	output reg low_power_out, // Low-power mode
	output reg out_hiz_out, // Amplifier output high impedance
	output reg in_internal_out, // Inputs on internal buffer network
	output reg divider_on_out, // Common-mode divider on supplies
	output reg normal_out, // Normal operation
	output reg store_out, // Store strobe for calibration memory
	output reg [7:0] cal_code_out // Stored calibration constants
);
	localparam ST_LOWPWR = 3'h0;
	localparam ST_PORWAIT = 3'h1;
	localparam ST_CAL = 3'h2;
	localparam ST_NORMAL = 3'h3;
	localparam ST_SUPLOW = 3'h4;

	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [`OCS_CNT_W-1:0] dly_reg;
	reg [`OCS_CNT_W-1:0] dly_next;
	reg cs_d_reg;
	wire cs_fall;
	wire dly_end;
	wire core_start;
	wire core_done;
	wire core_store;
	wire [`OCS_CAL_W-1:0] core_code;

	////////////////////////////////////////////////////////////////
	// State decodes shared by the core start logic and the output registers
	function is_low_power(input [2:0] st);
		is_low_power = (st == ST_LOWPWR) || (st == ST_SUPLOW) || (st == ST_PORWAIT);
	endfunction

	function is_cal(input [2:0] st);
		is_cal = (st == ST_CAL);
	endfunction

	function is_normal(input [2:0] st);
		is_normal = (st == ST_NORMAL);
	endfunction

	////////////////////////////////////////////////////////////////
	// Open pin reads low through the pull-down, as the reset value does: no false edge after reset
	assign cs_fall = cs_d_reg & ~cal_chip_select_first_in;
	// The wait stops short of the full turn-on time; the calibration that follows fills the rest
	assign dly_end = (dly_reg == PON_CYC - CON_CYC - 1);

	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_SUPLOW: if (!supply_low_in) state_next = ST_PORWAIT;
			ST_PORWAIT: begin
				if (dly_end) begin
					// Hold off until the pin is released
					if (cal_chip_select_first_in) state_next = ST_LOWPWR;
					else state_next = ST_CAL;
				end
			end
			ST_LOWPWR: if (cs_fall) state_next = ST_CAL;
			ST_CAL: if (core_done) state_next = ST_NORMAL;
			ST_NORMAL: if (cal_chip_select_first_in) state_next = ST_LOWPWR;
			default: state_next = ST_SUPLOW;
		endcase
		// A low supply outranks everything, a parity error outranks the pin
		if (supply_low_in) state_next = ST_SUPLOW;
		else if (parity_err_in) state_next = ST_PORWAIT;
	end

	// A parity error while already waiting restarts the delay rather than extending nothing
	always @* begin
		if (state_reg == ST_PORWAIT && state_next == ST_PORWAIT && !parity_err_in)
			dly_next = dly_reg + 1'b1;
		else
			dly_next = {`OCS_CNT_W{1'b0}};
	end

	assign core_start = is_cal(state_next) && !is_cal(state_reg);

	////////////////////////////////////////////////////////////////
	// Settling plus the correction steps is sized to fill the pin turn-on time
	ocs_offset_core #(.SETTLE_CYC(SETTLE_CYC)) ocs_offset_core_inst (
		.sys_clk_in(sys_clk_in),
		.rst_b_in(rst_b_in),
		.start_in(core_start),
		.comp_in(comp_in),
		.busy_out(),
		.done_out(core_done),
		.store_out(core_store),
		.code_out(core_code)
	);

	////////////////////////////////////////////////////////////////
	always @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			state_reg <= ST_SUPLOW;
			dly_reg <= {`OCS_CNT_W{1'b0}};
			cs_d_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			dly_reg <= dly_next;
			cs_d_reg <= cal_chip_select_first_in;
		end
	end

	////////////////////////////////////////////////////////////////
	// Mode outputs follow the next state, so each is a flop that moves with the state; store_out and cal_code_out follow the core
	always @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			low_power_out <= 1'b1;
			out_hiz_out <= 1'b1;
			in_internal_out <= 1'b0;
			divider_on_out <= 1'b0;
			normal_out <= 1'b0;
			store_out <= 1'b0;
			cal_code_out <= `OCS_CODE_RST;
		end else begin
			low_power_out <= is_low_power(state_next);
			out_hiz_out <= !is_normal(state_next);
			in_internal_out <= is_cal(state_next);
			divider_on_out <= is_cal(state_next);
			normal_out <= is_normal(state_next);
			// A run cut short by low supply or parity keeps going in the core; its result is dropped
			store_out <= core_store & is_cal(state_reg);
			if (core_store && is_cal(state_reg))
				cal_code_out <= core_code;
		end
	end
endmodule // ocs_seq

// ---- ocs_ctl_model.sv ----
// Controller model for the calibrate pin and comparator
`timescale 1ns/10ps
module ocs_ctl_model (
	input wire sys_clk_in, // Clock
	input wire want_in, // Wanted pin level
	input wire pos_in, // Offset sign
	input wire busy_in, // Calibration runs
	output reg pin_out = 1'b0, // Idles low
	output reg comp_out = 1'b0 // Comparator
);
	// Holds the pin still while a calibration runs
	always @(posedge sys_clk_in) begin
		if (!busy_in)
			pin_out <= #1 want_in;
		comp_out <= #1 pos_in;
	end
endmodule // ocs_ctl_model

// ---- ocs_seq_properties.sv ----
// Port checks for the sequencer
`timescale 1ns/10ps
module ocs_seq_properties #(parameter PON_CYC = 200, parameter CON_CYC = 42, parameter SETTLE_CYC = 10) (
	input wire sys_clk_in, // Clock
	input wire rst_b_in, // Reset
	input wire cal_chip_select_first_in, // Pin
	input wire supply_low_in, // Low supply
	input wire parity_err_in, // Parity
	input wire comp_in, // Comparator
	input wire low_power_out, // Low power
	input wire out_hiz_out, // Hiz
	input wire in_internal_out, // Internal
	input wire divider_on_out, // Divider
	input wire normal_out, // Normal
	input wire store_out, // Store
	input wire [7:0] cal_code_out // Code
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_b_in);
	// Length of the current calibration run, so its duration can be checked without long repetitions
	reg [31:0] cal_run_reg;
	always @(posedge sys_clk_in) begin
		if (!rst_b_in || !in_internal_out)
			cal_run_reg <= 32'h0;
		else
			cal_run_reg <= cal_run_reg + 32'h1;
	end
	sequence s_settle;
		(in_internal_out && !store_out)[*8];
	endsequence
	sequence s_resume;
		normal_out && !out_hiz_out && !in_internal_out;
	endsequence
	a_lp_hiz: assert property (low_power_out |-> out_hiz_out && !normal_out)
		else $error("low power not hiz");
	a_cal_isolated: assert property (in_internal_out |-> out_hiz_out && !normal_out && !low_power_out)
		else $error("calibration not isolated");
	a_divider_cal: assert property (divider_on_out == in_internal_out)
		else $error("divider outside calibration");
	a_settle_first: assert property ($rose(in_internal_out) |-> s_settle)
		else $error("store before settling");
	a_store_resume: assert property (store_out && !supply_low_in && !parity_err_in |=> s_resume)
		else $error("no resume after store");
	a_supply_low: assert property (supply_low_in |=> low_power_out && !in_internal_out && !normal_out)
		else $error("low supply not low power");
	a_recover_wait: assert property ($fell(supply_low_in) |-> (low_power_out && !in_internal_out)[*8])
		else $error("no delay on recovery");
	a_parity_restart: assert property (parity_err_in && !supply_low_in |=> low_power_out && !normal_out)
		else $error("parity error ignored");
	a_cal_length: assert property (store_out |-> cal_run_reg == SETTLE_CYC + 33)
		else $error("calibration length wrong");
endmodule // ocs_seq_properties
bind ocs_seq ocs_seq_properties #(.PON_CYC(PON_CYC), .CON_CYC(CON_CYC), .SETTLE_CYC(SETTLE_CYC)) ocs_seq_properties_inst (
	.sys_clk_in, .rst_b_in, .cal_chip_select_first_in, .supply_low_in, .parity_err_in, .comp_in, .low_power_out,
	.out_hiz_out, .in_internal_out, .divider_on_out, .normal_out, .store_out, .cal_code_out);

// ---- test_ocs_seq.sv ----
// Self-checking bench for the offset calibration sequencer
`timescale 1ns/10ps
module test_ocs_seq;
	localparam int PON = 200, CON = 42, SET = CON - 32;
	reg sys_clk_in = 1'b0, rst_b_in = 1'b0, supply_low_in = 1'b1, parity_err_in = 1'b0, want = 1'b0, pos = 1'b0;
	wire pin, comp, lp, hiz, intl, div, norm, store;
	wire [7:0] code;
	wire [7:0] st = {3'h0, norm, div, intl, hiz, lp};
	int failures = 0, n_compared = 0, cyc = 0, n;
	reg [7:0] prev;
	always #5 sys_clk_in = ~sys_clk_in;
	ocs_seq #(.PON_CYC(PON), .CON_CYC(CON), .SETTLE_CYC(SET)) ocs_seq_inst (.sys_clk_in, .rst_b_in,
		.cal_chip_select_first_in(pin), .supply_low_in, .parity_err_in, .comp_in(comp), .low_power_out(lp),
		.out_hiz_out(hiz), .in_internal_out(intl), .divider_on_out(div), .normal_out(norm), .store_out(store),
		.cal_code_out(code));
	ocs_ctl_model ocs_ctl_model_inst (.sys_clk_in, .want_in(want), .pos_in(pos), .busy_in(intl), .pin_out(pin),
		.comp_out(comp));
	task check(input string what, input [7:0] exp, input [7:0] got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task stop_test;
		if (failures == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge sys_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			stop_test;
		end
	end
	task tick(input int k);
		repeat (k) @(posedge sys_clk_in);
		#1;
	endtask
	// Bounded wait so a stuck state shows as a mismatch, not a hang
	task wait_hi(input int b);
		n = 0;
		while (st[b] !== 1'b1 && n < 400) begin
			tick(1);
			n++;
		end
	endtask
	task t_power_up;
		supply_low_in = 1'b0;
		wait_hi(2);
		check("delay", 8'h01, n >= PON - CON - 2 && n <= PON);
		wait_hi(4);
		check("cal", 8'h01, n >= SET + 32 && n <= SET + 36);
	endtask
	task t_pin(input bit p);
		pos = p;
		prev = code;
		want = 1'b1;
		tick(3);
		check("pin high", 8'h03, st);
		want = 1'b0;
		tick(3);
		check("calibrating", 8'h0e, st);
		wait_hi(4);
		check("turn-on", 8'h01, n >= SET + 28 && n <= SET + 34);
		check("code", 8'h01, p ? code < prev : code > prev);
		check("normal", 8'h10, st);
	endtask
	task t_hold;
		parity_err_in = 1'b1;
		tick(1);
		parity_err_in = 1'b0;
		tick(2);
		check("parity", 8'h03, st);
		want = 1'b1;
		tick(PON);
		check("held", 8'h03, st);
		want = 1'b0;
		wait_hi(4);
		check("release", 8'h01, n >= SET + 32 && n <= SET + 36);
	endtask
	task t_brownout;
		want = 1'b1;
		tick(3);
		want = 1'b0;
		tick(15);
		supply_low_in = 1'b1;
		tick(2);
		check("brownout", 8'h03, st);
	endtask
	initial begin
		tick(8);
		rst_b_in = 1'b1;
		tick(1);
		check("reset", 8'h03, st);
		check("reset code", 8'h80, code);
		t_power_up;
		t_pin(1'b1);
		t_pin(1'b0);
		t_hold;
		t_brownout;
		t_power_up;
		stop_test;
	end
endmodule // test_ocs_seq
